// ==== design/lin_status_flags_upper.v ====
// Operation
// - set rx flag on byte loaded, UART rx
// - set tx flag when buffer shifted out
// - tx flag cleared by buffer write, W1C
// - break over 22 bits sets flag
// - overlength flag cleared only by disable
// - 57 falling edges in frame sets flag
// - edge flag cleared by break detection
// - sleep mode long low then rise: wake
// - wake and sleep flags need software clear
// - bus unchanged past timeout sets sleep
// - bad start or stop bit: framing
// - break under 11 bits at sync: framing
// - framing cleared by W1C or disable
// - disable clears six flags
// - rx and tx flags drive event line
// - error flags drive error line
// - wake and sleep drive power line
// - rx flag cleared by buffer read, W1C
// - status zero after reset
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "lin_status_consts.vh"

module lin_status_flags_upper #(
  parameter integer LF_TICK = `LF_TICK_CYCLES,
  parameter integer SLEEP_SHIFT = `SLEEP_UNIT_SHIFT
) (
  input wire CLK,
  input wire RST,
  input wire [7:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [7:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  input wire LIN_RX,
  input wire RX_BYTE_VALID,
  input wire [7:0] RX_BYTE,
  input wire TX_SHIFT_DONE,
  input wire BREAK_DETECTED,
  input wire SYNC_RECEIVED,
  input wire CHAR_FRAME_FAULT,
  input wire FRAME_ACTIVE,
  output reg [7:0] TX_DATA,
  output reg TX_LOAD,
  output reg EVENT_IRQ_LINE,
  output reg ERROR_IRQ_LINE,
  output reg POWER_IRQ_LINE
);
  reg [3:0] control;
  reg [15:0] break_length_config;
  reg [15:0] wakeup_time_config;
  reg [15:0] sleep_timeout_config;
  reg [2:0] irq_mask;
  reg [7:0] bus_data_buffer;
  reg serial_rx_byte_flag;
  reg serial_tx_done_flag;
  reg break_overlength_flag;
  reg edge_limit_error_flag;
  reg wakeup_flag;
  reg bus_idle_sleep_flag;
  reg framing_error_flag;

  reg have_aw;
  reg have_w;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg bus_meta;
  reg bus_sync;
  reg bus_prev;
  reg [23:0] break_len;
  reg [5:0] edge_count;
  reg over_prev;
  reg idle_prev;

  wire enabled = control[`CTL_ENABLE];
  wire [15:0] status = {3'h0, serial_rx_byte_flag, serial_tx_done_flag,
    break_overlength_flag, edge_limit_error_flag, wakeup_flag,
    bus_idle_sleep_flag, framing_error_flag, 6'h00};

  // write is performed once both address and data are held
  wire do_write = have_aw && have_w && !BVALID;
  wire [31:0] byte_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wbits = w_data & byte_mask;
  wire wr_status = do_write && (aw_addr == `OFS_STATUS);
  wire wr_data = do_write && (aw_addr == `OFS_DATA) && w_strb[0];
  wire do_read = ARVALID && ARREADY;
  wire rd_data = do_read && (ARADDR == `OFS_DATA);
  wire [15:0] w1c = wr_status ? wbits[15:0] : 16'h0000;

  wire addr_ok_w = (aw_addr == `OFS_CONTROL) || (aw_addr == `OFS_STATUS) ||
    (aw_addr == `OFS_DATA) || (aw_addr == `OFS_BREAK_CFG) ||
    (aw_addr == `OFS_WAKE_CFG) || (aw_addr == `OFS_SLEEP_CFG) ||
    (aw_addr == `OFS_IRQ_MASK);

  // bus pin crossing and edge detection
  wire bus_fall = bus_prev && !bus_sync;
  wire bus_rise = !bus_prev && bus_sync;
  wire bus_change = bus_fall || bus_rise;
  wire lf_tick;
  wire [23:0] low_run;
  wire [31:0] idle_run;

  lf_tick_divider #(
    .DIV(LF_TICK)
  ) u_tick (
    .clk(CLK),
    .rst(RST),
    .tick(lf_tick)
  );

  // low duration in system clocks, used to judge break length
  duration_counter #(
    .W(24)
  ) u_low (
    .clk(CLK),
    .rst(RST),
    .clear(bus_change || bus_sync),
    .en(1'b1),
    .count(low_run)
  );

  // unchanged-bus duration in slow-clock ticks, for sleep and wake timing
  duration_counter #(
    .W(32)
  ) u_idle (
    .clk(CLK),
    .rst(RST),
    .clear(bus_change || !enabled),
    .en(lf_tick),
    .count(idle_run)
  );

  wire [23:0] bit_time = {8'h00, break_length_config};
  wire [23:0] max_break = bit_time * 24'd`BREAK_MAX_BITS;
  wire [23:0] min_break = bit_time * 24'd`BREAK_MIN_BITS;
  wire over_now = !bus_sync && (low_run > max_break);
  wire [31:0] sleep_limit = {16'h0000, sleep_timeout_config} << SLEEP_SHIFT;
  wire idle_now = idle_run > sleep_limit;

  // register the crossing points so a flag is raised once per event,
  // not re-raised every cycle after software clears it
  wire set_rx = enabled && control[`CTL_UART_RX] && RX_BYTE_VALID;
  wire set_tx = enabled && control[`CTL_UART_TX] && TX_SHIFT_DONE;
  wire set_over = enabled && over_now && !over_prev;
  wire set_edge = enabled && FRAME_ACTIVE && !BREAK_DETECTED && bus_fall &&
    (edge_count >= 6'd`EDGE_LIMIT - 6'd1);
  wire set_wake = enabled && control[`CTL_SLEEP] && bus_rise &&
    (idle_run > {16'h0000, wakeup_time_config});
  wire set_sleep = enabled && idle_now && !idle_prev;
  wire set_frm = enabled && (CHAR_FRAME_FAULT ||
    (SYNC_RECEIVED && (break_len < min_break)));

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      bus_meta <= 1'b1;
      bus_sync <= 1'b1;
      bus_prev <= 1'b1;
      break_len <= 24'h000000;
      edge_count <= 6'h00;
      over_prev <= 1'b0;
      idle_prev <= 1'b0;
    end else begin
      bus_meta <= LIN_RX;
      bus_sync <= bus_meta;
      bus_prev <= bus_sync;
      over_prev <= over_now;
      idle_prev <= idle_now;
      // the low run is still held in the cycle of the rising edge
      if (bus_rise && BREAK_DETECTED) begin
        break_len <= low_run;
      end else if (BREAK_DETECTED) begin
        break_len <= low_run + 24'h000001;
      end
      if (BREAK_DETECTED || !enabled || !FRAME_ACTIVE) begin
        edge_count <= 6'h00;
      end else if (bus_fall && (edge_count != 6'h3F)) begin
        edge_count <= edge_count + 6'h01;
      end
    end
  end

  // status flags: a set in the same cycle as a clear always wins
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      {serial_rx_byte_flag, serial_tx_done_flag, break_overlength_flag} <= 3'h0;
      {edge_limit_error_flag, wakeup_flag, bus_idle_sleep_flag} <= 3'h0;
      framing_error_flag <= 1'b0;
      bus_data_buffer <= 8'h00;
    end else begin
      if (set_rx) begin
        bus_data_buffer <= RX_BYTE;
      end else if (wr_data) begin
        bus_data_buffer <= wbits[7:0];
      end
      if (set_rx) begin
        serial_rx_byte_flag <= 1'b1;
      end else if (rd_data || w1c[`ST_RX_BYTE]) begin
        serial_rx_byte_flag <= 1'b0;
      end
      if (set_tx) begin
        serial_tx_done_flag <= 1'b1;
      end else if (wr_data || w1c[`ST_TX_DONE] || !enabled) begin
        serial_tx_done_flag <= 1'b0;
      end
      if (set_over) begin
        break_overlength_flag <= 1'b1;
      end else if (!enabled) begin
        break_overlength_flag <= 1'b0;
      end
      if (set_edge) begin
        edge_limit_error_flag <= 1'b1;
      end else if (BREAK_DETECTED || !enabled) begin
        edge_limit_error_flag <= 1'b0;
      end
      if (set_wake) begin
        wakeup_flag <= 1'b1;
      end else if (w1c[`ST_WAKEUP] || !enabled) begin
        wakeup_flag <= 1'b0;
      end
      if (set_sleep) begin
        bus_idle_sleep_flag <= 1'b1;
      end else if (w1c[`ST_SLEEP] || !enabled) begin
        bus_idle_sleep_flag <= 1'b0;
      end
      if (set_frm) begin
        framing_error_flag <= 1'b1;
      end else if (w1c[`ST_FRAMING] || !enabled) begin
        framing_error_flag <= 1'b0;
      end
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      EVENT_IRQ_LINE <= 1'b0;
      ERROR_IRQ_LINE <= 1'b0;
      POWER_IRQ_LINE <= 1'b0;
    end else begin
      EVENT_IRQ_LINE <= irq_mask[0] && (serial_rx_byte_flag || serial_tx_done_flag);
      ERROR_IRQ_LINE <= irq_mask[1] && (break_overlength_flag ||
        edge_limit_error_flag || framing_error_flag);
      POWER_IRQ_LINE <= irq_mask[2] && (wakeup_flag || bus_idle_sleep_flag);
    end
  end

  // AXI4-Lite write channel; address and data taken in either order
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= `RESP_OKAY;
      control <= `RST_CONTROL;
      break_length_config <= `RST_BREAK_CFG;
      wakeup_time_config <= `RST_WAKE_CFG;
      sleep_timeout_config <= `RST_SLEEP_CFG;
      irq_mask <= `RST_IRQ_MASK;
      TX_DATA <= 8'h00;
      TX_LOAD <= 1'b0;
    end else begin
      TX_LOAD <= 1'b0;
      if (AWVALID && AWREADY) begin
        have_aw <= 1'b1;
        aw_addr <= {AWADDR[7:2], 2'b00};
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        have_w <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
        WREADY <= 1'b0;
      end
      if (do_write) begin
        BVALID <= 1'b1;
        BRESP <= addr_ok_w ? `RESP_OKAY : `RESP_SLVERR;
        case (aw_addr)
          `OFS_CONTROL: begin
            if (w_strb[0]) begin
              control <= wbits[3:0];
            end
          end
          `OFS_DATA: begin
            if (w_strb[0]) begin
              TX_DATA <= wbits[7:0];
              TX_LOAD <= 1'b1;
            end
          end
          `OFS_BREAK_CFG: begin
            break_length_config <= (break_length_config & ~byte_mask[15:0]) | wbits[15:0];
          end
          `OFS_WAKE_CFG: begin
            wakeup_time_config <= (wakeup_time_config & ~byte_mask[15:0]) | wbits[15:0];
          end
          `OFS_SLEEP_CFG: begin
            sleep_timeout_config <= (sleep_timeout_config & ~byte_mask[15:0]) | wbits[15:0];
          end
          `OFS_IRQ_MASK: begin
            if (w_strb[0]) begin
              irq_mask <= wbits[2:0];
            end
          end
          default: begin
          end
        endcase
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        have_aw <= 1'b0;
        have_w <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= `RESP_OKAY;
    end else begin
      if (do_read) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RRESP <= `RESP_OKAY;
        case ({ARADDR[7:2], 2'b00})
          `OFS_CONTROL: RDATA <= {28'h0000000, control};
          `OFS_STATUS: RDATA <= {16'h0000, status};
          `OFS_DATA: RDATA <= {24'h000000, bus_data_buffer};
          `OFS_BREAK_CFG: RDATA <= {16'h0000, break_length_config};
          `OFS_WAKE_CFG: RDATA <= {16'h0000, wakeup_time_config};
          `OFS_SLEEP_CFG: RDATA <= {16'h0000, sleep_timeout_config};
          `OFS_IRQ_MASK: RDATA <= {29'h00000000, irq_mask};
          default: begin
            RDATA <= 32'h00000000;
            RRESP <= `RESP_SLVERR;
          end
        endcase
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end
endmodule

// ==== design/lin_status_consts.vh ====
`ifndef LIN_STATUS_CONSTS_VH
`define LIN_STATUS_CONSTS_VH

// register byte offsets on the AXI4-Lite bus
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_DATA 8'h08
`define OFS_BREAK_CFG 8'h0C
`define OFS_WAKE_CFG 8'h10
`define OFS_SLEEP_CFG 8'h14
`define OFS_IRQ_MASK 8'h18

// control register fields
`define CTL_ENABLE 0
`define CTL_UART_RX 1
`define CTL_UART_TX 2
`define CTL_SLEEP 3

// status register fields
`define ST_RX_BYTE 12
`define ST_TX_DONE 11
`define ST_BRK_OVER 10
`define ST_EDGE_LIM 9
`define ST_WAKEUP 8
`define ST_SLEEP 7
`define ST_FRAMING 6

// reset values
`define RST_STATUS 16'h0000
`define RST_CONTROL 4'h0
`define RST_BREAK_CFG 16'h03E8
`define RST_WAKE_CFG 16'h0005
`define RST_SLEEP_CFG 16'h0008
`define RST_IRQ_MASK 3'h0

// timing
`define CLK_PERIOD_NS 50
`define LF_PERIOD_NS 31250
`define LF_TICK_CYCLES (`LF_PERIOD_NS / `CLK_PERIOD_NS)
`define SLEEP_UNIT_SHIFT 14
`define BREAK_MAX_BITS 22
`define BREAK_MIN_BITS 11
`define EDGE_LIMIT 57

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== design/lf_tick_divider.v ====
`timescale 1ns/1ps
`include "lin_status_consts.vh"

module lf_tick_divider #(
  parameter integer DIV = `LF_TICK_CYCLES
) (
  input wire clk,
  input wire rst,
  output reg tick
);
  reg [15:0] count;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else if (count == DIV[15:0] - 16'h0001) begin
      count <= 16'h0000;
      tick <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

// ==== design/duration_counter.v ====
`timescale 1ns/1ps

module duration_counter #(
  parameter integer W = 24
) (
  input wire clk,
  input wire rst,
  input wire clear,
  input wire en,
  output reg [W-1:0] count
);
  // saturates so a bus stuck for hours never wraps back under a threshold
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= {W{1'b0}};
    end else if (clear) begin
      count <= {W{1'b0}};
    end else if (en && (count != {W{1'b1}})) begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ==== testbench/lin_node_model.sv ====
`timescale 1ns/1ps

module lin_node (
  input wire clk,
  output reg lin
);
  // the bus has a pull-up, so a released line reads high
  initial lin = 1'b1;

  // dominant pulse of n clocks, used for breaks and wake-up requests
  task low(input integer n);
    begin
      @(posedge clk);
      lin <= 1'b0;
      repeat (n) @(posedge clk);
      lin <= 1'b1;
      @(posedge clk);
    end
  endtask

  // short pulses are kept long enough for the receiver's two-flop synchroniser
  task edges(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        low(2);
        @(posedge clk);
      end
    end
  endtask
endmodule

// ==== testbench/lin_status_checker_properties.sv ====
`timescale 1ns/1ps
`include "lin_status_consts.vh"

module lin_status_checker (
  input wire CLK,
  input wire RST,
  input wire [7:0] AWADDR,
  input wire AWVALID,
  input wire AWREADY,
  input wire [31:0] WDATA,
  input wire WVALID,
  input wire WREADY,
  input wire [1:0] BRESP,
  input wire BVALID,
  input wire BREADY,
  input wire ARVALID,
  input wire ARREADY,
  input wire RVALID,
  input wire RX_BYTE_VALID,
  input wire TX_SHIFT_DONE,
  input wire CHAR_FRAME_FAULT,
  input wire TX_LOAD,
  input wire EVENT_IRQ_LINE,
  input wire ERROR_IRQ_LINE,
  input wire POWER_IRQ_LINE
);
  reg [7:0] aw;
  reg [31:0] wd;
  reg [3:0] ctl;
  reg [2:0] msk;
  wire bdone = BVALID && BREADY && BRESP == `RESP_OKAY;
  // shadow copies commit at the response, a cycle after the design, so they only lag
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      aw <= 8'h00;
      wd <= 32'h00000000;
      ctl <= 4'h0;
      msk <= 3'h0;
    end else begin
      if (AWVALID && AWREADY) aw <= AWADDR;
      if (WVALID && WREADY) wd <= WDATA;
      if (bdone && aw == `OFS_CONTROL) ctl <= wd[3:0];
      if (bdone && aw == `OFS_IRQ_MASK) msk <= wd[2:0];
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_rd_take;
    ARVALID && ARREADY;
  endsequence
  sequence s_off;
    !ctl[`CTL_ENABLE] [*3];
  endsequence

  property p_reset_idle;
    $fell(RST) |-> AWREADY && WREADY && ARREADY && !BVALID && !RVALID && !TX_LOAD
      && !EVENT_IRQ_LINE && !ERROR_IRQ_LINE && !POWER_IRQ_LINE;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  property p_resp_busy;
    BVALID |-> !AWREADY && !WREADY;
  endproperty
  a_resp_busy: assert property (p_resp_busy)
    else $error("write taken while response pending");
  property p_rd_answer;
    s_rd_take |=> RVALID && !ARREADY;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered next cycle");
  property p_tx_load;
    TX_LOAD |-> (aw == `OFS_DATA) ##1 !TX_LOAD;
  endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("transmit load not a single pulse from a data write");
  property p_rx_irq;
    ctl[`CTL_ENABLE] && ctl[`CTL_UART_RX] && msk[0] && RX_BYTE_VALID |-> ##2 EVENT_IRQ_LINE;
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("received byte did not raise event line");
  property p_tx_irq;
    ctl[`CTL_ENABLE] && ctl[`CTL_UART_TX] && msk[0] && TX_SHIFT_DONE |-> ##2 EVENT_IRQ_LINE;
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("transmit done did not raise event line");
  property p_frm_irq;
    ctl[`CTL_ENABLE] && msk[1] && CHAR_FRAME_FAULT |-> ##2 ERROR_IRQ_LINE;
  endproperty
  a_frm_irq: assert property (p_frm_irq)
    else $error("framing fault did not raise error line");
  property p_off;
    s_off |-> !ERROR_IRQ_LINE && !POWER_IRQ_LINE;
  endproperty
  a_off: assert property (p_off)
    else $error("error or power line high while disabled");
endmodule

bind lin_status_flags_upper lin_status_checker u_chk (
  .CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WDATA(WDATA), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
  .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
  .RX_BYTE_VALID(RX_BYTE_VALID), .TX_SHIFT_DONE(TX_SHIFT_DONE),
  .CHAR_FRAME_FAULT(CHAR_FRAME_FAULT), .TX_LOAD(TX_LOAD), .EVENT_IRQ_LINE(EVENT_IRQ_LINE),
  .ERROR_IRQ_LINE(ERROR_IRQ_LINE), .POWER_IRQ_LINE(POWER_IRQ_LINE)
);

// ==== testbench/lin_status_flags_upper_test.sv ====
`timescale 1ns/1ps
`include "lin_status_consts.vh"

module lin_status_flags_upper_test;
  reg CLK = 1'b0;
  reg RST = 1'b1;
  reg [7:0] AWADDR = 8'h00;
  reg AWVALID = 1'b0;
  reg [31:0] WDATA = 32'h00000000;
  reg [3:0] WSTRB = 4'hF;
  reg WVALID = 1'b0;
  reg BREADY = 1'b0;
  reg RREADY = 1'b0;
  reg [7:0] ARADDR = 8'h00;
  reg ARVALID = 1'b0;
  reg [7:0] RX_BYTE = 8'h00;
  reg FRAME_ACTIVE = 1'b0;
  reg [4:0] ev = 5'h00;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_LOAD, LIN_RX;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  wire [7:0] TX_DATA;
  wire EVENT_IRQ_LINE, ERROR_IRQ_LINE, POWER_IRQ_LINE;
  integer errors = 0;
  integer tests_run = 0;
  integer cyc = 0;
  reg [31:0] d;
  reg [1:0] r;
  localparam [4:0] E_RX = 5'h01, E_TX = 5'h02, E_BRK = 5'h04, E_SYN = 5'h08, E_FLT = 5'h10;

  always #25 CLK = ~CLK;

  // bit time 4 clocks, slow tick 4 clocks, sleep unit 4 ticks
  lin_status_flags_upper #(.LF_TICK(4), .SLEEP_SHIFT(2)) u_dut (
    .CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .LIN_RX(LIN_RX), .RX_BYTE_VALID(ev[0]), .RX_BYTE(RX_BYTE), .TX_SHIFT_DONE(ev[1]),
    .BREAK_DETECTED(ev[2]), .SYNC_RECEIVED(ev[3]), .CHAR_FRAME_FAULT(ev[4]),
    .FRAME_ACTIVE(FRAME_ACTIVE), .TX_DATA(TX_DATA), .TX_LOAD(TX_LOAD),
    .EVENT_IRQ_LINE(EVENT_IRQ_LINE), .ERROR_IRQ_LINE(ERROR_IRQ_LINE),
    .POWER_IRQ_LINE(POWER_IRQ_LINE)
  );
  lin_node u_node (.clk(CLK), .lin(LIN_RX));

  task test_done;
    begin
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask

  task chk(input [31:0] g, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("FAIL t=%0t got %h expected %h", $time, g, e);
      end
    end
  endtask

  // address and data go out together and drop independently once taken
  task wr(input [7:0] a, input [31:0] v);
    reg ad, wd;
    begin
      ad = 1'b0;
      wd = 1'b0;
      @(posedge CLK);
      AWADDR <= a;
      WDATA <= v;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (!(ad && wd)) begin
        @(posedge CLK);
        if (AWVALID && AWREADY) begin
          ad = 1'b1;
          AWVALID <= 1'b0;
        end
        if (WVALID && WREADY) begin
          wd = 1'b1;
          WVALID <= 1'b0;
        end
      end
      while (!BVALID) @(posedge CLK);
      r = BRESP;
      BREADY <= 1'b0;
    end
  endtask

  task rd(input [7:0] a);
    begin
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      @(posedge CLK);
      while (!ARREADY) @(posedge CLK);
      ARVALID <= 1'b0;
      @(posedge CLK);
      while (!RVALID) @(posedge CLK);
      d = RDATA;
      r = RRESP;
      RREADY <= 1'b0;
    end
  endtask

  task st(input [31:0] e);
    begin
      rd(`OFS_STATUS);
      chk(d, e);
    end
  endtask

  task pl(input [4:0] m);
    begin
      @(posedge CLK);
      ev <= m;
      @(posedge CLK);
      ev <= 5'h00;
      repeat (2) @(posedge CLK);
    end
  endtask

  // a status write is only trusted after two slow ticks
  task clr(input [31:0] v);
    begin
      wr(`OFS_STATUS, v);
      repeat (8) @(posedge CLK);
    end
  endtask

  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    st(32'h0);
    rd(8'hFC);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    wr(8'hFC, 32'h0);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    wr(`OFS_BREAK_CFG, 32'h4);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
    wr(`OFS_SLEEP_CFG, 32'hFFFF);
    wr(`OFS_IRQ_MASK, 32'h7);
    wr(`OFS_CONTROL, 32'h7);
    RX_BYTE <= 8'h5A;
    pl(E_RX);
    st(32'h1000);
    chk({31'h0, EVENT_IRQ_LINE}, 32'h1);
    clr(32'h0);
    st(32'h1000);
    rd(`OFS_DATA);
    chk(d, 32'h5A);
    st(32'h0);
    pl(E_RX);
    clr(32'h1000);
    st(32'h0);
    pl(E_TX);
    st(32'h800);
    wr(`OFS_DATA, 32'hA5);
    chk({24'h0, TX_DATA}, 32'hA5);
    st(32'h0);
    pl(E_TX);
    clr(32'h800);
    st(32'h0);
    pl(E_FLT);
    st(32'h40);
    chk({31'h0, ERROR_IRQ_LINE}, 32'h1);
    clr(32'h40);
    st(32'h0);
    FRAME_ACTIVE <= 1'b1;
    u_node.edges(56);
    st(32'h0);
    u_node.edges(1);
    st(32'h200);
    pl(E_BRK);
    st(32'h0);
    FRAME_ACTIVE <= 1'b0;
    u_node.low(40);
    pl(E_BRK);
    pl(E_SYN);
    st(32'h40);
    clr(32'h40);
    u_node.low(100);
    pl(E_BRK);
    pl(E_SYN);
    st(32'h400);
    clr(32'h400);
    st(32'h400);
    wr(`OFS_CONTROL, 32'h9);
    u_node.low(40);
    repeat (4) @(posedge CLK);
    st(32'h500);
    chk({31'h0, POWER_IRQ_LINE}, 32'h1);
    repeat (50) @(posedge CLK);
    st(32'h500);
    clr(32'h100);
    st(32'h400);
    wr(`OFS_SLEEP_CFG, 32'h1);
    repeat (40) @(posedge CLK);
    st(32'h480);
    wr(`OFS_CONTROL, 32'h0);
    st(32'h0);
    chk({30'h0, ERROR_IRQ_LINE, POWER_IRQ_LINE}, 32'h0);
    // only the strobed byte may change
    WSTRB <= 4'h2;
    wr(`OFS_WAKE_CFG, 32'h0000AB00);
    WSTRB <= 4'hF;
    rd(`OFS_WAKE_CFG);
    chk(d, 32'h0000AB00 | {16'h0000, `RST_WAKE_CFG});
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
    test_done;
  end

  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc > 10000) begin
      errors = errors + 1;
      test_done;
    end
  end
endmodule
